// >>> verilog/trip_monitor_data_port.v
/*
  Indirect data port of the threshold-trip monitor. Holds the control
  register (bank selects and entry index) and three entry banks: low
  thresholds, high thresholds and the channel list. Exports the entry
  chosen by the comparison engine's lookup index.
  Assumes a synchronous register port: one-cycle write or read strobes,
  never both at once; read data appear in the cycle after the read strobe.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "trip_monitor_consts.vh"

module trip_monitor_data_port
(
  input  wire                      clk_in,
  input  wire                      sys_rst_in,
  input  wire [`TM_ADDR_W-1:0]     addr_in,
  input  wire [`TM_DATA_W-1:0]     wr_data_in,
  input  wire                      wr_strobe_in,
  input  wire                      rd_strobe_in,
  output wire [`TM_DATA_W-1:0]     rd_data_out,
  output wire                      list_bank_select_out,
  output wire                      low_high_select_out,
  output wire [`TM_IDX_MSB:0]      entry_index_out,
  input  wire [`TM_IDX_MSB:0]      lookup_index_in,
  output wire [`TM_CMP_W-1:0]      low_threshold_out,
  output wire [`TM_CMP_W-1:0]      high_threshold_out,
  output wire [`TM_LIST_CH_W-1:0]  channel_number_out,
  output wire                      differential_flag_out
);

////////////////////////////////////////////////////////////////////////////////
// Declarations
reg                       list_bank_select_reg;
reg                       list_bank_select_next;
reg                       low_high_select_reg;
reg                       low_high_select_next;
reg  [`TM_IDX_MSB:0]      entry_index_reg;
reg  [`TM_IDX_MSB:0]      entry_index_next;
reg  [`TM_DATA_W-1:0]     rd_data_reg;
reg  [`TM_DATA_W-1:0]     rd_data_next;
reg  [`TM_DATA_W-1:0]     port_value;
reg  [`TM_DATA_W-1:0]     ctrl_value;
reg  [`TM_CMP_W-1:0]      low_threshold_reg;
reg  [`TM_CMP_W-1:0]      high_threshold_reg;
reg  [`TM_LIST_CH_W-1:0]  channel_number_reg;
reg                       differential_flag_reg;

wire                      data_sel;
wire                      ctrl_sel;
wire                      data_wr;
wire                      data_rd;
wire                      ctrl_wr;
wire                      low_we;
wire                      high_we;
wire                      list_we;
wire [`TM_THR_W-1:0]      thr_wr_value;
wire [`TM_LIST_W-1:0]     list_wr_value;
wire [`TM_THR_W-1:0]      low_sw_value;
wire [`TM_THR_W-1:0]      high_sw_value;
wire [`TM_LIST_W-1:0]     list_sw_value;
wire [`TM_THR_W-1:0]      low_lk_value;
wire [`TM_THR_W-1:0]      high_lk_value;
wire [`TM_LIST_W-1:0]     list_lk_value;

////////////////////////////////////////////////////////////////////////////////
// Address decode
assign data_sel = (addr_in == `TM_ADDR_DATA);
assign ctrl_sel = (addr_in == `TM_ADDR_CTRL);
assign data_wr  = wr_strobe_in & data_sel;
assign data_rd  = rd_strobe_in & data_sel;
assign ctrl_wr  = wr_strobe_in & ctrl_sel;

////////////////////////////////////////////////////////////////////////////////
// Bank write enables
assign low_we  = data_wr & ~list_bank_select_reg & ~low_high_select_reg;
assign high_we = data_wr & ~list_bank_select_reg & low_high_select_reg;
assign list_we = data_wr & list_bank_select_reg;

// Upper data-port bits are dropped on writes
assign thr_wr_value  = wr_data_in[`TM_THR_MSB:0];
assign list_wr_value = wr_data_in[`TM_LIST_MSB:0];

////////////////////////////////////////////////////////////////////////////////
// Entry banks
trip_entry_bank
#(
  .WIDTH (`TM_THR_W)
)
low_bank
(
  .clk_in        (clk_in),
  .sys_rst_in    (sys_rst_in),
  .wr_en_in      (low_we),
  .wr_idx_in     (entry_index_reg),
  .wr_data_in    (thr_wr_value),
  .rd_idx_a_in   (entry_index_reg),
  .rd_data_a_out (low_sw_value),
  .rd_idx_b_in   (lookup_index_in),
  .rd_data_b_out (low_lk_value)
);

trip_entry_bank
#(
  .WIDTH (`TM_THR_W)
)
high_bank
(
  .clk_in        (clk_in),
  .sys_rst_in    (sys_rst_in),
  .wr_en_in      (high_we),
  .wr_idx_in     (entry_index_reg),
  .wr_data_in    (thr_wr_value),
  .rd_idx_a_in   (entry_index_reg),
  .rd_data_a_out (high_sw_value),
  .rd_idx_b_in   (lookup_index_in),
  .rd_data_b_out (high_lk_value)
);

trip_entry_bank
#(
  .WIDTH (`TM_LIST_W)
)
list_bank
(
  .clk_in        (clk_in),
  .sys_rst_in    (sys_rst_in),
  .wr_en_in      (list_we),
  .wr_idx_in     (entry_index_reg),
  .wr_data_in    (list_wr_value),
  .rd_idx_a_in   (entry_index_reg),
  .rd_data_a_out (list_sw_value),
  .rd_idx_b_in   (lookup_index_in),
  .rd_data_b_out (list_lk_value)
);

////////////////////////////////////////////////////////////////////////////////
// Data-port read value, reserved bits zero
always @*
begin
  port_value = `TM_ZERO16;
  if (list_bank_select_reg)
    port_value[`TM_LIST_MSB:0] = list_sw_value;
  else if (low_high_select_reg)
    port_value[`TM_THR_MSB:0] = high_sw_value;
  else
    port_value[`TM_THR_MSB:0] = low_sw_value;
end

// Control register read value
always @*
begin
  ctrl_value = `TM_ZERO16;
  ctrl_value[`TM_CTRL_LIST_BIT] = list_bank_select_reg;
  ctrl_value[`TM_CTRL_LH_BIT]   = low_high_select_reg;
  ctrl_value[`TM_IDX_MSB:0]     = entry_index_reg;
end

////////////////////////////////////////////////////////////////////////////////
// Control register next state
always @*
begin
  list_bank_select_next = list_bank_select_reg;
  low_high_select_next  = low_high_select_reg;
  entry_index_next      = entry_index_reg;
  if (ctrl_wr)
  begin
    list_bank_select_next = wr_data_in[`TM_CTRL_LIST_BIT];
    low_high_select_next  = wr_data_in[`TM_CTRL_LH_BIT];
    entry_index_next      = wr_data_in[`TM_IDX_MSB:0];
  end
  else if (data_wr || data_rd)
  begin
    entry_index_next = entry_index_reg + `TM_IDX_ONE;
  end
end

// Read data stand only in the cycle after the read strobe
always @*
begin
  rd_data_next = `TM_ZERO16;
  if (rd_strobe_in)
  begin
    if (data_sel)
      rd_data_next = port_value;
    else if (ctrl_sel)
      rd_data_next = ctrl_value;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
always @(posedge clk_in or posedge sys_rst_in)
begin
  if (sys_rst_in)
  begin
    list_bank_select_reg <= 1'b0;
    low_high_select_reg  <= 1'b0;
    entry_index_reg      <= `TM_IDX_RESET;
    rd_data_reg          <= `TM_ZERO16;
  end
  else
  begin
    list_bank_select_reg <= list_bank_select_next;
    low_high_select_reg  <= low_high_select_next;
    entry_index_reg      <= entry_index_next;
    rd_data_reg          <= rd_data_next;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Comparison-side export, one cycle after the lookup index
always @(posedge clk_in or posedge sys_rst_in)
begin
  if (sys_rst_in)
  begin
    low_threshold_reg     <= {`TM_CMP_W{1'b0}};
    high_threshold_reg    <= {`TM_CMP_W{1'b0}};
    channel_number_reg    <= {`TM_LIST_CH_W{1'b0}};
    differential_flag_reg <= 1'b0;
  end
  else
  begin
    low_threshold_reg     <= low_lk_value[`TM_THR_MSB:`TM_CMP_LSB];
    high_threshold_reg    <= high_lk_value[`TM_THR_MSB:`TM_CMP_LSB];
    channel_number_reg    <= list_lk_value[`TM_LIST_CH_MSB:0];
    differential_flag_reg <= list_lk_value[`TM_LIST_DIFFERENTIAL_FLAG_BIT];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs
assign rd_data_out           = rd_data_reg;
assign list_bank_select_out  = list_bank_select_reg;
assign low_high_select_out   = low_high_select_reg;
assign entry_index_out       = entry_index_reg;
assign low_threshold_out     = low_threshold_reg;
assign high_threshold_out    = high_threshold_reg;
assign channel_number_out    = channel_number_reg;
assign differential_flag_out = differential_flag_reg;

endmodule

// >>> verilog/trip_monitor_consts.vh
/*
  Constants for the trip monitor indirect data port: register addresses,
  control field positions, entry widths and reset values.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef TRIP_MONITOR_CONSTS_VH
`define TRIP_MONITOR_CONSTS_VH

// Register addresses
`define TM_ADDR_W          4
`define TM_ADDR_DATA       4'h0
`define TM_ADDR_CTRL       4'h1

// Control register layout
`define TM_CTRL_LIST_BIT   7
`define TM_CTRL_LH_BIT     4
`define TM_IDX_MSB         3
`define TM_IDX_W           4
`define TM_IDX_ONE         4'h1
`define TM_IDX_RESET       4'h0

// Data port layout
`define TM_DATA_W          16
`define TM_ZERO16          16'h0000
`define TM_THR_W           10
`define TM_THR_MSB         9
`define TM_CMP_LSB         2
`define TM_CMP_W           8
`define TM_LIST_W          5
`define TM_LIST_MSB        4
`define TM_LIST_DIFFERENTIAL_FLAG_BIT   4
`define TM_LIST_CH_MSB     3
`define TM_LIST_CH_W       4

// Entry storage
`define TM_ENTRIES         16

`endif

// >>> verilog/trip_entry_bank.v
/*
  Bank of sixteen entries of parameter width, one write port and two
  combinational read ports (software side and comparison side).
  Assumes one clock and an asynchronous active-high reset that clears all entries.
*/
`timescale 1ns/10ps
`include "trip_monitor_consts.vh"

module trip_entry_bank
#(
  parameter WIDTH = `TM_THR_W
)
(
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  input  wire                  wr_en_in,
  input  wire [`TM_IDX_MSB:0]  wr_idx_in,
  input  wire [WIDTH-1:0]      wr_data_in,
  input  wire [`TM_IDX_MSB:0]  rd_idx_a_in,
  output wire [WIDTH-1:0]      rd_data_a_out,
  input  wire [`TM_IDX_MSB:0]  rd_idx_b_in,
  output wire [WIDTH-1:0]      rd_data_b_out
);

wire [WIDTH-1:0]       entry_reg_flat [0:`TM_ENTRIES-1];
wire [`TM_ENTRIES-1:0] wr_hit;

// One-hot write select, avoids slicing the loop variable
assign wr_hit = {{(`TM_ENTRIES-1){1'b0}}, wr_en_in} << wr_idx_in;

////////////////////////////////////////////////////////////////////////////////
// One storage word per entry
genvar g;
generate
  for (g = 0; g < `TM_ENTRIES; g = g + 1)
  begin : entry
    reg [WIDTH-1:0] value_reg;
    always @(posedge clk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
        value_reg <= {WIDTH{1'b0}};
      else if (wr_hit[g])
        value_reg <= wr_data_in;
    end
    assign entry_reg_flat[g] = value_reg;
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read ports
assign rd_data_a_out = entry_reg_flat[rd_idx_a_in];
assign rd_data_b_out = entry_reg_flat[rd_idx_b_in];

endmodule

// >>> verif/trip_monitor_data_port_properties.sv
/* Checker for the trip monitor data port register side.
   Assumes a bind onto the top module ports, one clock domain. */
`timescale 1ns/10ps
`include "trip_monitor_consts.vh"
module trip_monitor_data_port_properties
(
  input wire                  clk_in,
  input wire                  sys_rst_in,
  input wire [`TM_ADDR_W-1:0] addr_in,
  input wire [`TM_DATA_W-1:0] wr_data_in,
  input wire                  wr_strobe_in,
  input wire                  rd_strobe_in,
  input wire [`TM_DATA_W-1:0] rd_data_out,
  input wire                  list_bank_select_out,
  input wire                  low_high_select_out,
  input wire [`TM_IDX_MSB:0]  entry_index_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire data_acc = (wr_strobe_in || rd_strobe_in) && addr_in == 4'h0;
  AST_IDX_ADVANCE: assert property (data_acc |=> entry_index_out == $past(entry_index_out) + 4'h1)
    else $error("index did not advance");
  AST_IDX_HOLD: assert property (!wr_strobe_in && !data_acc |=> $stable(entry_index_out))
    else $error("index moved without access");
  AST_CTRL_LOAD: assert property (wr_strobe_in && addr_in == 4'h1 |=> entry_index_out ==
    $past(wr_data_in[3:0]) && list_bank_select_out == $past(wr_data_in[7]) &&
    low_high_select_out == $past(wr_data_in[4]))
    else $error("control load wrong");
  AST_SEL_KEEP: assert property (data_acc |=> $stable(low_high_select_out))
    else $error("select moved on data access");
  AST_THR_TOP_ZERO: assert property (data_acc && rd_strobe_in && !list_bank_select_out
    |=> rd_data_out[15:10] == 6'h00)
    else $error("threshold top bits set");
  AST_LIST_TOP_ZERO: assert property (data_acc && rd_strobe_in && list_bank_select_out
    |=> rd_data_out[15:5] == 11'h000)
    else $error("list top bits set");
  AST_IDLE_ZERO: assert property (!rd_strobe_in ##1 1'b1 |-> rd_data_out == 16'h0000)
    else $error("read data outside answer");
  AST_UNMAPPED: assert property (rd_strobe_in && addr_in > 4'h1 |=> rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
  C_LIST_RD: cover property (data_acc && rd_strobe_in && list_bank_select_out);
  C_WRAP: cover property (data_acc && entry_index_out == 4'hF);
  C_CTRL_RD: cover property (rd_strobe_in && addr_in == 4'h1);
endmodule

// >>> verif/test_trip_monitor_data_port.sv
/* Self-checking bench for the trip monitor data port.
   Assumes the design header is on the include path. */
`timescale 1ns/10ps
`include "trip_monitor_consts.vh"
module test_trip_monitor_data_port;
  reg         clk_in = 1'b0;
  reg         sys_rst_in = 1'b1;
  reg  [3:0]  addr_in = 4'h0;
  reg  [15:0] wr_data_in = 16'h0000;
  reg         wr_strobe_in = 1'b0;
  reg         rd_strobe_in = 1'b0;
  reg  [3:0]  lookup_index_in = 4'h0;
  wire [15:0] rd_data_out;
  wire        list_bank_select_out;
  wire        low_high_select_out;
  wire [3:0]  entry_index_out;
  wire [7:0]  low_threshold_out;
  wire [7:0]  high_threshold_out;
  wire [3:0]  channel_number_out;
  wire        differential_flag_out;
  integer     failures = 0;
  integer     total_checks = 0;
  integer     i;
  reg  [15:0] got;
  reg  [47:0] rows [0:5];
  trip_monitor_data_port i_trip_monitor_data_port
  (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
    .list_bank_select_out(list_bank_select_out), .low_high_select_out(low_high_select_out),
    .entry_index_out(entry_index_out), .lookup_index_in(lookup_index_in),
    .low_threshold_out(low_threshold_out), .high_threshold_out(high_threshold_out),
    .channel_number_out(channel_number_out), .differential_flag_out(differential_flag_out)
  );
  always #25 clk_in = ~clk_in;
  task check_word(input [8*8:1] name, input [15:0] exp, input [15:0] seen);
  begin
    total_checks = total_checks + 1;
    if (exp !== seen)
    begin
      failures = failures + 1;
      $display("mismatch %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task check_small(input [8*8:1] name, input [7:0] exp, input [7:0] seen);
  begin
    check_word(name, {8'h00, exp}, {8'h00, seen});
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_strobe_in <= 1'b1;
    @(posedge clk_in);
    wr_strobe_in <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk_in);
    addr_in <= a;
    rd_strobe_in <= 1'b1;
    @(posedge clk_in);
    rd_strobe_in <= 1'b0;
    #1 got = rd_data_out;
  end
  endtask
  task look(input [3:0] k, input [7:0] lo, input [7:0] hi, input [4:0] lst);
  begin
    @(posedge clk_in);
    lookup_index_in <= k;
    @(posedge clk_in);
    #1 check_small("low", lo, low_threshold_out);
    check_small("high", hi, high_threshold_out);
    check_small("list", {3'h0, lst}, {3'h0, differential_flag_out, channel_number_out});
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    failures = failures + 1;
    report_and_stop;
  end
  initial
  begin
    rows[0] = {16'h0000, 16'h0100, 16'h0100};
    rows[1] = {16'h0010, 16'h03AC, 16'h03AC};
    rows[2] = {16'h0090, 16'h0015, 16'h0015};
    rows[3] = {16'h0005, 16'hFFFF, 16'h03FF};
    rows[4] = {16'h008F, 16'hFFFF, 16'h001F};
    rows[5] = {16'h001F, 16'h02AC, 16'h02AC};
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 check_small("ctrl", 8'h00, {list_bank_select_out, low_high_select_out, entry_index_out});
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(4'h1, rows[i][47:32]);
      wr(4'h0, rows[i][31:16]);
      wr(4'h1, rows[i][47:32]);
      rd(4'h0);
      check_word("entry", rows[i][15:0], got);
      check_small("index", {4'h0, rows[i][35:32] + 4'h1}, {4'h0, entry_index_out});
    end
    $display("table done");
    look(4'h0, 8'h40, 8'hEB, 5'h15);
    look(4'h5, 8'hFF, 8'h00, 5'h00);
    look(4'hF, 8'h00, 8'hAB, 5'h1F);
    $display("lookup done");
    wr(4'h1, 16'h00B3);
    wr(4'h7, 16'h00FF);
    rd(4'h7);
    check_word("unmapped", 16'h0000, got);
    rd(4'h1);
    check_word("ctrl_rd", 16'h0093, got);
    $display("unmapped done");
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 check_small("rst_ctl", 8'h00, {list_bank_select_out, low_high_select_out, entry_index_out});
    rd(4'h0);
    check_word("rst_ent", 16'h0000, got);
    $display("reset done");
    report_and_stop;
  end
endmodule
bind trip_monitor_data_port trip_monitor_data_port_properties i_props
(
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
  .list_bank_select_out(list_bank_select_out), .low_high_select_out(low_high_select_out),
  .entry_index_out(entry_index_out)
);
